//--- design/interval_timer_pkg.sv
/*
  Shared constants and carrier types of the interval timer host port.
  Assumes an 8-bit host bus with two address bits and active-low strobes.
*/
package interval_timer_pkg;

  // ------------------------------------------------------------
  // Port map
  // ------------------------------------------------------------
  localparam logic [7:0] counter_zero_port = 8'h80;
  localparam logic [7:0] counter_one_port = 8'h81;
  localparam logic [7:0] counter_two_port = 8'h82;
  localparam logic [7:0] timer_control_word = 8'h83;
  localparam logic [1:0] sel_control = 2'h3;

  // ------------------------------------------------------------
  // Control byte fields
  // ------------------------------------------------------------
  localparam int ctl_sel_pos = 6;
  localparam int ctl_acc_pos = 4;
  localparam int ctl_mode_pos = 1;
  localparam int ctl_bcd_pos = 0;

  // Access formats
  localparam logic [1:0] acc_latch = 2'h0;
  localparam logic [1:0] acc_high = 2'h1;
  localparam logic [1:0] acc_low = 2'h2;
  localparam logic [1:0] acc_both = 2'h3;

  // Counting modes
  localparam logic [2:0] mode_term = 3'h0;
  localparam logic [2:0] mode_one_shot = 3'h1;
  localparam logic [2:0] mode_rate = 3'h2;
  localparam logic [2:0] mode_square = 3'h3;
  localparam logic [2:0] mode_strobe = 3'h4;
  localparam logic [2:0] mode_hw_strobe = 3'h5;

  // Reset values
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] data_reset = 8'h00;

  // Largest counts
  localparam logic [15:0] max_binary = 16'hFFFF;
  localparam logic [15:0] max_bcd = 16'h9999;

  // Number of counters
  localparam int num_counters = 3;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  // Per-counter configuration taken from a control byte
  typedef struct packed {
    logic [1:0] access;
    logic [2:0] mode;
    logic bcd;
  } counter_cfg_s;

  // Host bus request as seen by the port logic
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [7:0] data;
  } host_bus_s;

endpackage

//--- design/bcd_decrement.sv
/*
  Decrements a 16-bit count by one or two, in binary or four BCD digits.
  Purely combinational; a zero count wraps to FFFF in binary or 9999 in BCD.
*/
`timescale 1ns/1ps
module bcd_decrement (
  // Operand
  input wire logic [15:0] value,
  input wire logic bcd,
  input wire logic by_two,
  // Result
  output logic [15:0] result
);
  import interval_timer_pkg::*;

  // ------------------------------------------------------------
  // One-step decrement helper
  // ------------------------------------------------------------
  function automatic logic [15:0] dec1(input logic [15:0] v,
                                        input logic b);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!b) begin
      // Binary wraps 0 to the full range
      r = v - 16'h0001;
    end else begin
      // Each digit borrows from its neighbour; 0 becomes 9
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[i*4 +: 4] == 4'h0) begin
            r[i*4 +: 4] = 4'h9;
          end else begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // Two steps reuse the same helper
  always_comb begin
    result = dec1(value, bcd);
    if (by_two) begin
      result = dec1(dec1(value, bcd), bcd);
    end
  end

endmodule

//--- design/timer_counter_unit.sv
/*
  One 16-bit down-counter with its own count-clock enable and gate.
  Assumes count_tick is a one-cycle pulse synchronous to clock.
*/
`timescale 1ns/1ps
module timer_counter_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Count rate and gate
  input wire logic count_tick,
  input wire logic gate,
  // Programming
  input wire logic cfg_load,
  input wire interval_timer_pkg::counter_cfg_s cfg_in,
  input wire logic value_load,
  input wire logic [15:0] value_in,
  input wire logic hold,
  // State
  output logic [15:0] count,
  output logic out_level,
  output logic programmed
);
  import interval_timer_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  counter_cfg_s cfg, next_cfg;  // Mode and BCD choice
  logic [15:0] reload, next_reload;  // Last loaded value
  logic [15:0] next_count;
  logic next_out_level, next_programmed;
  logic armed, next_armed;  // Count loaded, counting allowed
  logic [15:0] dec_value;
  logic by_two;

  // Square wave counts by two from an even count, by one from an odd count
  assign by_two = (cfg.mode == mode_square) && !count[0];

  bcd_decrement u_dec (
    .value(count),
    .bcd(cfg.bcd),
    .by_two(by_two),
    .result(dec_value)
  );

  // Zero count means the largest count for the current number system
  function automatic logic [15:0] full_count(input logic [15:0] v,
                                              input logic b);
    logic [15:0] r;
    r = v;
    if (v == 16'h0000) begin
      r = b ? max_bcd : max_binary;  // [R15]
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_reload = reload;
    next_count = count;
    next_out_level = out_level;
    next_programmed = programmed;
    next_armed = armed;
    if (cfg_load) begin
      // New mode: output idles per mode until a count arrives
      next_cfg = cfg_in;
      next_armed = 1'b0;
      next_out_level = (cfg_in.mode != mode_term);
      next_programmed = 1'b0;
    end else if (value_load) begin
      next_reload = value_in;
      next_count = full_count(value_in, cfg.bcd);  // [R15]
      next_armed = 1'b1;
      next_programmed = 1'b1;
      next_out_level = (cfg.mode != mode_term);
    end else if (armed && gate && !hold && count_tick) begin
      // Decrement toward zero at the external rate [R2] [R3] [R13]
      next_count = dec_value;
      unique case (cfg.mode)
        mode_term: begin
          // Output rises at zero and stays; counting wraps on [R10]
          if (count == 16'h0001) begin
            next_out_level = 1'b1;
          end
        end
        mode_rate: begin
          // Repeating interval: one low tick, then reload [R10]
          next_out_level = (count != 16'h0002);
          if (count == 16'h0001) begin
            next_count = full_count(reload, cfg.bcd);
          end
        end
        mode_square: begin
          // Half high, half low, then reload
          if (count <= 16'h0002) begin
            next_out_level = !out_level;
            next_count = full_count(reload, cfg.bcd);
          end
        end
        mode_strobe: begin
          // Single low tick after the delay [R10]
          next_out_level = (count != 16'h0001);
        end
        default: begin
          // Modes without a gate trigger only count down
          next_out_level = out_level;
        end
      endcase
    end
  end

  // Registers; contents undefined to software until programmed [R5]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg <= '0;
      reload <= count_reset;
      count <= count_reset;
      out_level <= 1'b0;
      programmed <= 1'b0;
      armed <= 1'b0;
    end else begin
      cfg <= next_cfg;
      reload <= next_reload;
      count <= next_count;
      out_level <= next_out_level;
      programmed <= next_programmed;
      armed <= next_armed;
    end
  end

endmodule

//--- design/interval_timer_host_port.sv
/*
  Host-facing port of a three-counter interval timer.
  Assumes bus strobes and count-clock pulses are synchronous to clock.
*/
//
// Summary of operation
// (R1) Three independent 16-bit counters
// (R2) Count down at own external clock rate
// (R3) Binary or BCD counting per counter
// (R4) Four locations: three counters, one control
// (R5) Unprogrammed counter state is undefined
// (R6) Host writes control byte before counts
// (R7) Top two control bits select counter
// (R8) Access format shapes transfer; strobe picks direction
// (R9) Programming one counter leaves others alone
// (R10) Counter can give periodic or single event
// (R11) Host must not reprogram counters zero, one
// (R12) Format: latch, high, low, both low-first
// (R13) BCD bit chooses four decimal digits
// (R14) Three-bit mode field, values zero to five
// (R15) Zero load gives maximum count
// (R16) Decode address, select, strobes; one byte each
`timescale 1ns/1ps
module interval_timer_host_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_in,
  // Read data and its drive enable
  output logic [7:0] data_out,
  output logic data_oe,
  // Counter clocks and gates
  input wire logic [2:0] count_tick,
  input wire logic [2:0] gate,
  // Counter outputs
  output logic [2:0] timer_out
);
  import interval_timer_pkg::*;

  // ------------------------------------------------------------
  // Bus strobe edge detection
  // ------------------------------------------------------------
  logic rd_prev, wr_prev, next_rd_prev, next_wr_prev;
  logic rd_start, wr_start;
  logic [1:0] sel;

  // A cycle acts once, on the strobe's falling edge [R16]
  assign rd_start = !cs_n && !rd_n && rd_prev;
  assign wr_start = !cs_n && !wr_n && wr_prev;
  assign sel = addr;

  always_comb begin
    next_rd_prev = rd_n || cs_n;
    next_wr_prev = wr_n || cs_n;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= next_rd_prev;
      wr_prev <= next_wr_prev;
    end
  end

  // ------------------------------------------------------------
  // Per-counter transfer state
  // ------------------------------------------------------------
  logic [1:0] access [num_counters];  // Current format
  logic [1:0] next_access [num_counters];
  logic [7:0] low_hold [num_counters];  // Low byte awaiting high
  logic [7:0] next_low_hold [num_counters];
  logic wr_phase [num_counters];  // High byte expected next
  logic next_wr_phase [num_counters];
  logic rd_phase [num_counters];
  logic next_rd_phase [num_counters];
  logic [15:0] latch_val [num_counters];  // Frozen read value
  logic [15:0] next_latch_val [num_counters];
  logic latched [num_counters];
  logic next_latched [num_counters];
  logic [7:0] next_data_out;
  logic next_data_oe;
  logic [15:0] rd_src;  // Byte source for a counter read

  // Per-counter strobes into the units
  logic [2:0] cfg_load, value_load, hold;
  logic [15:0] value_in [num_counters];
  logic [15:0] count [num_counters];
  logic [2:0] unit_out;  // Output levels of the units
  counter_cfg_s cfg_in;

  // Control byte fields [R7] [R12] [R14] [R13]
  logic [1:0] ctl_sel;
  assign ctl_sel = data_in[ctl_sel_pos +: 2];
  assign cfg_in.access = data_in[ctl_acc_pos +: 2];
  assign cfg_in.mode = data_in[ctl_mode_pos +: 3];
  assign cfg_in.bcd = data_in[ctl_bcd_pos];

  // ------------------------------------------------------------
  // Counters, each independent of the others [R1] [R9]
  // ------------------------------------------------------------
  for (genvar i = 0; i < num_counters; i++) begin : g_cnt
    timer_counter_unit u_unit (
      .clock(clock),
      .rst(rst),
      .count_tick(count_tick[i]),
      .gate(gate[i]),
      .cfg_load(cfg_load[i]),
      .cfg_in(cfg_in),
      .value_load(value_load[i]),
      .value_in(value_in[i]),
      .hold(hold[i]),
      .count(count[i]),
      .out_level(unit_out[i]),
      .programmed()
    );
  end

  // ------------------------------------------------------------
  // Decode and transfer sequencing
  // ------------------------------------------------------------
  // The firmware owns counters zero and one; nothing is blocked
  // here, since protecting them is the host's duty [R11]
  always_comb begin
    next_data_out = data_out;
    next_data_oe = !cs_n && !rd_n;
    // Frozen latch if one is pending, else the live count; the
    // control location has no counter behind it
    rd_src = count_reset;
    if (sel != sel_control) begin
      rd_src = latched[sel] ? latch_val[sel] : count[sel];
    end
    cfg_load = 3'h0;
    value_load = 3'h0;
    for (int i = 0; i < num_counters; i++) begin
      next_access[i] = access[i];
      next_low_hold[i] = low_hold[i];
      next_wr_phase[i] = wr_phase[i];
      next_rd_phase[i] = rd_phase[i];
      next_latch_val[i] = latch_val[i];
      next_latched[i] = latched[i];
      value_in[i] = {data_in, data_in};
      // A counter in any mode pauses while a two-byte load is half done
      hold[i] = wr_phase[i] && access[i] == acc_both;
    end
    if (wr_start && sel == sel_control) begin
      // Control byte arrives before counts [R6] [R4]
      if (ctl_sel != 2'h3) begin
        if (cfg_in.access == acc_latch) begin
          // Latch command leaves mode and BCD alone [R12]
          next_latch_val[ctl_sel] = count[ctl_sel];
          next_latched[ctl_sel] = 1'b1;
        end else begin
          cfg_load[ctl_sel] = 1'b1;
          next_access[ctl_sel] = cfg_in.access;
          next_wr_phase[ctl_sel] = 1'b0;
          next_rd_phase[ctl_sel] = 1'b0;
        end
      end
    end else if (wr_start) begin
      // Count load, shaped by the access format [R8] [R12]
      unique case (access[sel])
        acc_high: begin
          value_in[sel] = {data_in, 8'h00};
          value_load[sel] = 1'b1;
        end
        acc_low: begin
          value_in[sel] = {8'h00, data_in};
          value_load[sel] = 1'b1;
        end
        acc_both: begin
          if (!wr_phase[sel]) begin
            next_low_hold[sel] = data_in;
            next_wr_phase[sel] = 1'b1;
          end else begin
            value_in[sel] = {data_in, low_hold[sel]};
            value_load[sel] = 1'b1;
            next_wr_phase[sel] = 1'b0;
          end
        end
        default: begin
          // No format yet: the byte is ignored
          value_load[sel] = 1'b0;
        end
      endcase
    end else if (rd_start && sel != sel_control) begin
      // Read a counter or its frozen latch [R4] [R8]
      unique case (access[sel])
        acc_high: begin
          next_data_out = rd_src[15:8];
          next_latched[sel] = 1'b0;
        end
        acc_both: begin
          next_data_out = rd_phase[sel] ? rd_src[15:8] : rd_src[7:0];
          next_rd_phase[sel] = !rd_phase[sel];
          if (rd_phase[sel]) begin
            next_latched[sel] = 1'b0;
          end
        end
        default: begin
          next_data_out = rd_src[7:0];
          next_latched[sel] = 1'b0;
        end
      endcase
    end else if (rd_start) begin
      // Control location reads return zero
      next_data_out = data_reset;
    end
  end

  // Transfer registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_out <= data_reset;
      data_oe <= 1'b0;
      timer_out <= 3'h0;
      for (int i = 0; i < num_counters; i++) begin
        access[i] <= acc_latch;
        low_hold[i] <= data_reset;
        wr_phase[i] <= 1'b0;
        rd_phase[i] <= 1'b0;
        latch_val[i] <= count_reset;
        latched[i] <= 1'b0;
      end
    end else begin
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      timer_out <= unit_out;
      for (int i = 0; i < num_counters; i++) begin
        access[i] <= next_access[i];
        low_hold[i] <= next_low_hold[i];
        wr_phase[i] <= next_wr_phase[i];
        rd_phase[i] <= next_rd_phase[i];
        latch_val[i] <= next_latch_val[i];
        latched[i] <= next_latched[i];
      end
    end
  end

endmodule

//--- verification/interval_timer_host_sva.sv
/*
  Checker for the interval timer host port, bound to its top module.
  Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module interval_timer_host_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host bus
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // Counters
  input wire logic [2:0] count_tick,
  input wire logic [2:0] gate,
  input wire logic [2:0] timer_out
);
  // ----------------------------------------
  // Timing frame
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Read taken on the first edge of a strobe
  sequence rd_take;
    !cs_n && !rd_n && ($past(rd_n) || $past(cs_n));
  endsequence
  // Write cycle, read strobe idle
  sequence wr_take;
    !cs_n && !wr_n && rd_n;
  endsequence
  // No bus traffic, no count pulses, gates steady
  sequence quiet;
    (cs_n && count_tick == 3'h0 && $stable(gate)) [*3];
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oe_rise: assert property (rd_take |=> data_oe)
    else $error("read enable missing after read strobe");
  a_oe_fall: assert property ((cs_n || rd_n) |=> !data_oe)
    else $error("read enable high without read strobe");
  a_oe_hold: assert property ((!cs_n && !rd_n) [*2] |-> data_oe)
    else $error("read enable dropped inside read strobe");
  a_ctl_zero: assert property (
    (rd_take ##0 addr == 2'h3) |=> data_out == 8'h00)
    else $error("control location read not zero");
  a_data_hold: assert property (
    !(!cs_n && !rd_n && ($past(rd_n) || $past(cs_n)))
    |=> $stable(data_out))
    else $error("read data changed without a read");
  a_write_quiet: assert property (
    wr_take |=> !data_oe ##1 !data_oe)
    else $error("write cycle drove the data bus");
  a_out_quiet: assert property (quiet |=> $stable(timer_out))
    else $error("counter output moved without count pulse");
  a_reset_quiet: assert property (
    $fell(rst) |-> (!data_oe && data_out == 8'h00 && timer_out == 3'h0))
    else $error("outputs not at reset values after reset");
endmodule

//--- verification/host_cpu_model.sv
/*
  Host processor model: byte-wide I/O cycles towards the timer port.
  Assumes strobes are sampled on the rising edge of the timer clock.
*/
`timescale 1ns/1ps
module host_cpu_model (
  // Clock
  input wire logic clock,
  // Bus towards the timer
  output interval_timer_pkg::host_bus_s bus,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  import interval_timer_pkg::*;

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Idle bus, strobes high
  initial begin
    bus = '{1'b1, 1'b1, 1'b1, 2'h0, 8'hA5};
  end

  // One byte per strobe, released after the taking edge
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    #2;
    bus = '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge clock);
    #2;
    // Released data lines show no stale byte
    bus = '{1'b1, 1'b1, 1'b1, a, ~d};
    @(posedge clock);
  endtask

  // Strobe held through the answer edge, byte taken there
  task automatic bus_rd(input logic [1:0] a, output logic [7:0] d,
                        output logic oe);
    @(posedge clock);
    #2;
    bus = '{1'b0, 1'b0, 1'b1, a, ~bus.data};
    @(posedge clock);
    @(posedge clock);
    #1;
    d = data_out;
    oe = data_oe;
    #1;
    bus = '{1'b1, 1'b1, 1'b1, a, ~bus.data};
    @(posedge clock);
  endtask
endmodule

//--- verification/interval_timer_host_port_test.sv
/*
  Self-checking bench for the interval timer host port.
  Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module interval_timer_host_port_test;
  import interval_timer_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock;
  logic rst;
  logic [2:0] count_tick; // Count pulses per counter
  logic [2:0] gate; // Count enables
  host_bus_s bus; // Host cycles from the model
  logic [7:0] data_out;
  logic data_oe;
  logic [2:0] timer_out;
  int fail_count;
  int checks;
  int cycles;
  logic [15:0] v;
  logic [7:0] b;
  logic oe;

  interval_timer_host_port u_interval_timer_host_port (
    .clock(clock), .rst(rst), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .wr_n(bus.wr_n), .addr(bus.addr), .data_in(bus.data),
    .data_out(data_out), .data_oe(data_oe), .count_tick(count_tick),
    .gate(gate), .timer_out(timer_out));
  host_cpu_model u_host_cpu_model (
    .clock(clock), .bus(bus), .data_out(data_out), .data_oe(data_oe));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // The tests need well under a tenth of this ceiling
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Control byte first, then low and high byte
  task automatic load(logic [1:0] c, logic [7:0] ctl, logic [15:0] val);
    u_host_cpu_model.bus_wr(2'h3, ctl);
    u_host_cpu_model.bus_wr(c, val[7:0]);
    u_host_cpu_model.bus_wr(c, val[15:8]);
  endtask
  // Latch command, then both bytes low first; keeps counting undisturbed
  task automatic latch(logic [1:0] c, output logic [15:0] val);
    logic [7:0] lo;
    logic [7:0] hi;
    logic e;
    u_host_cpu_model.bus_wr(2'h3, {c, 6'h00});
    u_host_cpu_model.bus_rd(c, lo, e);
    u_host_cpu_model.bus_rd(c, hi, e);
    val = {hi, lo};
  endtask
  // One-cycle count pulses, each followed by a gap
  task automatic tick(int i, int n);
    repeat (n) begin
      @(posedge clock);
      #2;
      count_tick[i] = 1'b1;
      @(posedge clock);
      #2;
      count_tick[i] = 1'b0;
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    count_tick = 3'h0;
    gate = 3'h7;
    repeat (12) @(posedge clock);
    #2;
    rst = 1'b0;
    // Control location is write-only and reads as zero
    u_host_cpu_model.bus_rd(timer_control_word[1:0], b, oe);
    chk("control read", 16'h0000, {8'h00, b});
    chk("read enable", 16'h0001, {15'h0, oe});
    $display("Test bus done");
    // Display counters set up once only, read later by latch
    load(2'h0, 8'h34, 16'h1234);
    load(2'h1, 8'h74, 16'h0456);
    // Counter 2, mode 0, binary, both bytes
    load(2'h2, 8'hB0, 16'h0005);
    #2;
    chk("out after load", 16'h0000, {15'h0, timer_out[2]});
    tick(2, 2);
    latch(2'h2, v);
    chk("count after ticks", 16'h0003, v);
    #2;
    gate[2] = 1'b0;
    tick(2, 1);
    latch(2'h2, v);
    chk("gate low holds", 16'h0003, v);
    #2;
    gate[2] = 1'b1;
    tick(2, 3);
    repeat (4) @(posedge clock);
    #1;
    chk("out at zero", 16'h0001, {15'h0, timer_out[2]});
    $display("Test mode zero done");
    // Select 3 is no counter; the others stay untouched
    u_host_cpu_model.bus_wr(2'h3, 8'hF0);
    latch(2'h2, v);
    chk("select three ignored", 16'h0000, v);
    chk("select three out", 16'h0001, {15'h0, timer_out[2]});
    latch(2'h0, v);
    chk("counter 0 kept", 16'h1234, v);
    latch(2'h1, v);
    chk("counter 1 kept", 16'h0456, v);
    tick(0, 1);
    latch(2'h0, v);
    chk("counter 0 own clock", 16'h1233, v);
    $display("Test independence done");
    // Single-byte formats, read back directly
    u_host_cpu_model.bus_wr(2'h3, 8'h90);
    u_host_cpu_model.bus_wr(2'h2, 8'h12);
    u_host_cpu_model.bus_rd(2'h2, b, oe);
    chk("high byte only", 16'h0012, {8'h00, b});
    u_host_cpu_model.bus_wr(2'h3, 8'hA0);
    u_host_cpu_model.bus_wr(2'h2, 8'h34);
    u_host_cpu_model.bus_rd(2'h2, b, oe);
    chk("low byte only", 16'h0034, {8'h00, b});
    $display("Test formats done");
    // Zero loads and decimal counting
    load(2'h2, 8'hB1, 16'h0000);
    latch(2'h2, v);
    chk("decimal max", max_bcd, v);
    tick(2, 1);
    latch(2'h2, v);
    chk("decimal step", 16'h9998, v);
    load(2'h2, 8'hB1, 16'h0100);
    tick(2, 1);
    latch(2'h2, v);
    chk("decimal borrow", 16'h0099, v);
    load(2'h2, 8'hB0, 16'h0000);
    latch(2'h2, v);
    chk("binary max", max_binary, v);
    tick(2, 1);
    latch(2'h2, v);
    chk("binary step", 16'hFFFE, v);
    $display("Test counting done");
    // Rate mode: one low tick at the end, then reload and go high
    load(2'h2, 8'hB4, 16'h0003);
    tick(2, 2);
    @(posedge clock);
    #2;
    chk("rate low tick", 16'h0000, {15'h0, timer_out[2]});
    tick(2, 1);
    latch(2'h2, v);
    chk("rate reload", 16'h0003, v);
    chk("rate high again", 16'h0001, {15'h0, timer_out[2]});
    // Strobe mode: a single low tick once the delay has run out
    load(2'h2, 8'hB8, 16'h0002);
    tick(2, 2);
    @(posedge clock);
    #2;
    chk("strobe low tick", 16'h0000, {15'h0, timer_out[2]});
    tick(2, 1);
    @(posedge clock);
    #2;
    chk("strobe single", 16'h0001, {15'h0, timer_out[2]});
    // Every mode code is accepted with its load
    for (int m = 0; m < 6; m++) begin
      load(2'h2, 8'hB0 | (8'(m) << 1), 16'h0010);
      latch(2'h2, v);
      chk("mode load", 16'h0010, v);
    end
    $display("Test modes done");
    final_report();
  end
endmodule

bind interval_timer_host_port interval_timer_host_sva
  u_interval_timer_host_sva (
  .clock(clock), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .count_tick(count_tick), .gate(gate), .timer_out(timer_out));
